// ### hdl/sslenc_pkg.sv
// Constants, register map and types of the status LED encoder.
// Assumes one 40 MHz system clock shared by every module that imports it.
package sslenc_pkg;

  // ************************************************************
  // Clock and blink timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned BLINK_SLOW_PERIOD_NS = 1_000_000_000;
  localparam int unsigned BLINK_FAST_PERIOD_NS = 333_333_333;
  // Half periods in clock cycles, rounded down
  localparam int unsigned BLINK_SLOW_HALF_CYC =
    BLINK_SLOW_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned BLINK_FAST_HALF_CYC =
    BLINK_FAST_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned DIMM_COUNT = 8;
  localparam int unsigned FAN_CNT_W = 4;
  localparam int unsigned AXI_ADDR_W = 4;
  localparam int unsigned IRQ_W = 3;

  // ************************************************************
  // Register map (byte addresses) and fields
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATE = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  localparam int unsigned CTRL_PSU_RED_BIT = 0;
  localparam int unsigned CTRL_FAN_RED_BIT = 1;
  localparam int unsigned CTRL_FAN_MIN_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  localparam int unsigned IRQ_CHANGE_BIT = 0;
  localparam int unsigned IRQ_AMBER_BIT = 1;
  localparam int unsigned IRQ_FATAL_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    DISP_OFF, DISP_GREEN_SOLID, DISP_GREEN_BLINK,
    DISP_AMBER_BLINK, DISP_AMBER_SOLID
  } sslenc_disp_t;
  typedef enum logic [1:0] {
    MGMT_READY, MGMT_LOADER, MGMT_OS_BOOT, MGMT_IMAGE_BAD
  } sslenc_mgmt_t;
  typedef enum logic [2:0] {
    SLP_S0, SLP_S1, SLP_S2, SLP_S3, SLP_S4, SLP_S5
  } sslenc_sleep_t;

endpackage

// ### hdl/sslenc_blink_if.sv
// Blink phase carried from a divider to the LED encoder.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface sslenc_blink_if;
  logic phase;
  logic toggle;
  modport gen (output phase, output toggle);
  modport use_side (input phase, input toggle);
endinterface

// ### hdl/sslenc_divider.sv
// Square wave divider for LED blinking, 50 percent duty.
// Assumes a synchronised active-low reset.
`timescale 1ns/1ps
module sslenc_divider #(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  sslenc_blink_if.gen blink
);
  import sslenc_pkg::*;

  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_ff;
  logic phase_ff;
  logic toggle_ff;

  // ************************************************************
  // Half-period counter and phase
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      phase_ff <= 1'b0;
      toggle_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      phase_ff <= ~phase_ff;
      toggle_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
      toggle_ff <= 1'b0;
    end
  end

  assign blink.phase = phase_ff;
  assign blink.toggle = toggle_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_BLINK_HALF: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_ff != $past(phase_ff)) |-> $past(cnt_ff) == LAST)
    else $error("blink phase moved before half period ended");
endmodule

// ### hdl/sslenc_irq.sv
// Sticky event status with write-one-to-clear and a masked interrupt.
// Assumes a synchronised active-low reset; a set beats a clear.
`timescale 1ns/1ps
module sslenc_irq #(
  parameter int unsigned W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] status,
  output logic irq
);
  import sslenc_pkg::*;

  logic [W-1:0] status_ff;
  logic [W-1:0] nxt_status;
  logic irq_ff;

  // Set wins over a clear in the same cycle
  assign nxt_status = (status_ff & ~clr) | set;

  // ************************************************************
  // Status bits and interrupt level
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask);
    end
  end

  assign status = status_ff;
  assign irq = irq_ff;

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    irq_ff == |(status_ff & $past(mask)))
    else $error("interrupt level disagrees with masked status");
endmodule

// ### hdl/sslenc_top.sv
// Status LED encoder: board conditions to a green/amber indicator.
// Assumes condition inputs synchronous to CLK_SYS; AXI4-Lite registers.
// Contract
// - Select green, amber or neither per state.
// - Dark when off, low-standby, S5 or S4.
// - Steady green only when healthy S0, booted.
// - Green blink on configured redundancy loss.
// - Green blink on fan fault above minimum.
// - Green blink on non-critical threshold crossing.
// - Green blink on predictive failure with redundancy.
// - Green blink on degraded memory.
// - Light migrated DIMM fault LED too.
// - Green blink in loader; chassis ID 3Hz.
// - Green blink in OS boot; chassis ID on.
// - Green blink on watchdog, battery, config error.
// - Green blink on drive controller fault.
// - Amber blink on critical threshold crossing.
// - Amber blink on overtemp, fans, drive, power.
// - Steady amber on fatal conditions.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module sslenc_top #(
  parameter int unsigned SLOW_HALF_CYC = sslenc_pkg::BLINK_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = sslenc_pkg::BLINK_FAST_HALF_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [sslenc_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [sslenc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SYS_POWERED,
  input wire logic LOW_STANDBY_OFF_STATE,
  input wire sslenc_pkg::sslenc_sleep_t SLEEP_STATE,
  input wire logic AC_PRESENT,
  input wire sslenc_pkg::sslenc_mgmt_t MGMT_BOOT_STAGE,
  input wire logic PSU_REDUNDANCY_LOST,
  input wire logic FAN_REDUNDANCY_LOST,
  input wire logic FAN_WARN,
  input wire logic FAN_FAIL,
  input wire logic [sslenc_pkg::FAN_CNT_W-1:0] FAN_OK_COUNT,
  input wire logic [4:0] NONCRIT_THRESH,
  input wire logic [3:0] CRIT_THRESH,
  input wire logic PROCESSOR_HOT_FLAG,
  input wire logic PSU_PREDICTIVE_FAIL,
  input wire logic MEM_DIMM_DISABLED,
  input wire logic MEM_MIRROR_ERR,
  input wire logic [sslenc_pkg::DIMM_COUNT-1:0] SPARE_MIGRATE_DIMM,
  input wire logic MGMT_WATCHDOG_RESET,
  input wire logic BATTERY_FAIL,
  input wire logic PWR_UNIT_CFG_ERR,
  input wire logic DRIVE_HOT_SWAP_CONTROLLER_FAULT,
  input wire logic REGULATOR_OVERTEMP_FLAG,
  input wire logic DRIVE_FAULT,
  input wire logic PWR_UNIT_INSUFFICIENT,
  input wire logic PROCESSOR_CATASTROPHIC_ERROR,
  input wire logic THERMAL_TRIP,
  input wire logic POWER_GOOD,
  input wire logic MEM_UNCORRECTABLE,
  output logic LED_GREEN,
  output logic LED_AMBER,
  output logic CHASSIS_ID_LED,
  output logic [sslenc_pkg::DIMM_COUNT-1:0] DIMM_FAULT_LED,
  output logic IRQ
);
  import sslenc_pkg::*;

  // ************************************************************
  // Reset release and blink sources
  // ************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n_s;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n_s = rst_sync_ff;

  sslenc_blink_if slow_if ();
  sslenc_blink_if fast_if ();

  sslenc_divider #(.HALF_CYC(SLOW_HALF_CYC)) u_slow_div (
    .clk(CLK_SYS),
    .rst_n(rst_n_s),
    .blink(slow_if.gen)
  );
  sslenc_divider #(.HALF_CYC(FAST_HALF_CYC)) u_fast_div (
    .clk(CLK_SYS),
    .rst_n(rst_n_s),
    .blink(fast_if.gen)
  );

  // ************************************************************
  // Condition classification
  // ************************************************************
  logic [31:0] ctrl_ff;
  logic psu_red_cfg;
  logic fan_red_cfg;
  logic [FAN_CNT_W-1:0] fan_min;
  logic pwr_dark;
  logic fatal;
  logic amber_cond;
  logic green_cond;
  logic healthy;
  sslenc_disp_t nxt_disp;
  sslenc_disp_t disp_ff;

  assign psu_red_cfg = ctrl_ff[CTRL_PSU_RED_BIT];
  assign fan_red_cfg = ctrl_ff[CTRL_FAN_RED_BIT];
  assign fan_min = ctrl_ff[CTRL_FAN_MIN_LSB +: FAN_CNT_W];

  // Power state, fatal, amber and green condition groups
  always_comb begin
    pwr_dark = !SYS_POWERED || LOW_STANDBY_OFF_STATE ||
               SLEEP_STATE == SLP_S5 || SLEEP_STATE == SLP_S4;
    fatal = PROCESSOR_CATASTROPHIC_ERROR || THERMAL_TRIP ||
            !POWER_GOOD || MEM_UNCORRECTABLE ||
            MGMT_BOOT_STAGE == MGMT_IMAGE_BAD;
    amber_cond = (|CRIT_THRESH) || PROCESSOR_HOT_FLAG;
    amber_cond = amber_cond || REGULATOR_OVERTEMP_FLAG || DRIVE_FAULT ||
                 FAN_OK_COUNT < fan_min || PWR_UNIT_INSUFFICIENT;
    green_cond = (PSU_REDUNDANCY_LOST && psu_red_cfg) ||
                 (FAN_REDUNDANCY_LOST && fan_red_cfg);
    green_cond = green_cond ||
                 ((FAN_WARN || FAN_FAIL) && FAN_OK_COUNT > fan_min);
    green_cond = green_cond || (|NONCRIT_THRESH);
    green_cond = green_cond || (PSU_PREDICTIVE_FAIL && psu_red_cfg);
    green_cond = green_cond || MEM_DIMM_DISABLED || MEM_MIRROR_ERR ||
                 (|SPARE_MIGRATE_DIMM);
    green_cond = green_cond || MGMT_BOOT_STAGE == MGMT_LOADER;
    green_cond = green_cond || MGMT_BOOT_STAGE == MGMT_OS_BOOT;
    green_cond = green_cond || MGMT_WATCHDOG_RESET || BATTERY_FAIL ||
                 PWR_UNIT_CFG_ERR;
    green_cond = green_cond || DRIVE_HOT_SWAP_CONTROLLER_FAULT;
    healthy = SLEEP_STATE == SLP_S0 && AC_PRESENT &&
              MGMT_BOOT_STAGE == MGMT_READY;
  end

  // Display choice by priority
  always_comb begin
    if (pwr_dark) begin
      nxt_disp = DISP_OFF;
    end else if (fatal) begin
      nxt_disp = DISP_AMBER_SOLID;
    end else if (amber_cond) begin
      nxt_disp = DISP_AMBER_BLINK;
    end else if (green_cond) begin
      nxt_disp = DISP_GREEN_BLINK;
    end else if (healthy) begin
      nxt_disp = DISP_GREEN_SOLID;
    end else begin
      nxt_disp = DISP_OFF;
    end
  end

  // ************************************************************
  // Indicator outputs
  // ************************************************************
  logic led_green_ff;
  logic led_amber_ff;
  logic chassis_ff;
  logic [DIMM_COUNT-1:0] dimm_led_ff;

  // Colour element drive per display state
  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) begin
      disp_ff <= DISP_OFF;
      led_green_ff <= 1'b0;
      led_amber_ff <= 1'b0;
    end else begin
      disp_ff <= nxt_disp;
      unique case (nxt_disp)
        DISP_OFF: begin
          led_green_ff <= 1'b0;
          led_amber_ff <= 1'b0;
        end
        DISP_GREEN_SOLID: begin
          led_green_ff <= 1'b1;
          led_amber_ff <= 1'b0;
        end
        DISP_GREEN_BLINK: begin
          led_green_ff <= slow_if.phase;
          led_amber_ff <= 1'b0;
        end
        DISP_AMBER_BLINK: begin
          led_green_ff <= 1'b0;
          led_amber_ff <= slow_if.phase;
        end
        DISP_AMBER_SOLID: begin
          led_green_ff <= 1'b0;
          led_amber_ff <= 1'b1;
        end
      endcase
    end
  end

  // Chassis identification and DIMM fault indicators
  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) begin
      chassis_ff <= 1'b0;
      dimm_led_ff <= '0;
    end else begin
      unique case (MGMT_BOOT_STAGE)
        MGMT_READY: chassis_ff <= 1'b0;
        MGMT_LOADER: chassis_ff <= fast_if.phase;
        MGMT_OS_BOOT: chassis_ff <= 1'b1;
        MGMT_IMAGE_BAD: chassis_ff <= 1'b1;
      endcase
      dimm_led_ff <= pwr_dark ? '0 : SPARE_MIGRATE_DIMM;
    end
  end

  assign LED_GREEN = led_green_ff;
  assign LED_AMBER = led_amber_ff;
  assign CHASSIS_ID_LED = chassis_ff;
  assign DIMM_FAULT_LED = dimm_led_ff;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic awready_ff;
  logic wready_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [AXI_ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [3:0] rd_addr;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_status;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_addr = {aw_addr_ff[3:2], 2'h0};
  assign rd_addr = {S_AXI_ARADDR[3:2], 2'h0};

  // Write address and data capture, in either order
  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else begin
      if (S_AXI_AWVALID && awready_ff) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
        aw_addr_ff <= S_AXI_AWADDR;
      end else if (bvalid_ff && S_AXI_BREADY) begin
        aw_held_ff <= 1'b0;
        awready_ff <= 1'b1;
      end else if (!aw_held_ff) begin
        awready_ff <= 1'b1;
      end
      if (S_AXI_WVALID && wready_ff) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
        w_data_ff <= S_AXI_WDATA;
        w_strb_ff <= S_AXI_WSTRB;
      end else if (bvalid_ff && S_AXI_BREADY) begin
        w_held_ff <= 1'b0;
        wready_ff <= 1'b1;
      end else if (!w_held_ff) begin
        wready_ff <= 1'b1;
      end
    end
  end

  // Register writes and write response
  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_ff <= CTRL_RESET;
      irq_mask_ff <= IRQ_MASK_RESET;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= RESP_OKAY;
      unique case (wr_addr)
        ADDR_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb_ff[i]) begin
              ctrl_ff[8*i +: 8] <= w_data_ff[8*i +: 8];
            end
          end
        end
        ADDR_IRQ_MASK: begin
          if (w_strb_ff[0]) begin
            irq_mask_ff <= w_data_ff[IRQ_W-1:0];
          end
        end
        ADDR_STATE, ADDR_IRQ_STATUS: bresp_ff <= RESP_OKAY;
        default: bresp_ff <= RESP_DECERR;
      endcase
    end else if (bvalid_ff && S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      unique case (rd_addr)
        ADDR_CTRL: rdata_ff <= ctrl_ff;
        ADDR_STATE: rdata_ff <= {27'h0, led_amber_ff, led_green_ff, disp_ff};
        ADDR_IRQ_STATUS: rdata_ff <= {29'h0, irq_status};
        ADDR_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
        default: begin
          rdata_ff <= '0;
          rresp_ff <= RESP_DECERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  // ************************************************************
  // Interrupt events
  // ************************************************************
  // Display change, entry to amber blink, entry to steady amber
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_CHANGE_BIT] = nxt_disp != disp_ff;
    irq_set[IRQ_AMBER_BIT] = nxt_disp == DISP_AMBER_BLINK &&
                             disp_ff != DISP_AMBER_BLINK;
    irq_set[IRQ_FATAL_BIT] = nxt_disp == DISP_AMBER_SOLID &&
                             disp_ff != DISP_AMBER_SOLID;
    irq_clr = (wr_fire && wr_addr == ADDR_IRQ_STATUS && w_strb_ff[0]) ?
              w_data_ff[IRQ_W-1:0] : '0;
  end

  sslenc_irq #(.W(IRQ_W)) u_irq (
    .clk(CLK_SYS),
    .rst_n(rst_n_s),
    .set(irq_set),
    .clr(irq_clr),
    .mask(irq_mask_ff),
    .status(irq_status),
    .irq(IRQ)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  logic chk_en_ff;
  // Checks start a cycle after reset
  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) chk_en_ff <= 1'b0;
    else chk_en_ff <= 1'b1;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!chk_en_ff);

  AST_OFF_DARK: assert property (
    pwr_dark |=> !led_green_ff && !led_amber_ff)
    else $error("indicator lit while system is off");
  AST_GREEN_SOLID: assert property (
    !pwr_dark && healthy && !fatal && !amber_cond && !green_cond
    |=> led_green_ff && !led_amber_ff)
    else $error("healthy system not shown steady green");
  AST_FATAL_AMBER: assert property (
    !pwr_dark && fatal |=> led_amber_ff && !led_green_ff
    && disp_ff == DISP_AMBER_SOLID)
    else $error("fatal condition not shown steady amber");
  AST_AMBER_BLINK: assert property (
    !pwr_dark && !fatal && amber_cond
    |=> !led_green_ff && led_amber_ff == $past(slow_if.phase))
    else $error("amber blink not following blink phase");
  AST_GREEN_BLINK: assert property (
    !pwr_dark && !fatal && !amber_cond && green_cond
    |=> !led_amber_ff && led_green_ff == $past(slow_if.phase))
    else $error("green blink not following blink phase");
  AST_DIMM_LED: assert property (
    !pwr_dark |=> dimm_led_ff == $past(SPARE_MIGRATE_DIMM))
    else $error("DIMM fault indicator does not match migration");
  AST_CHASSIS_OS: assert property (
    MGMT_BOOT_STAGE == MGMT_OS_BOOT |=> chassis_ff)
    else $error("chassis indicator dark during OS boot");
  AST_CHASSIS_LDR: assert property (
    MGMT_BOOT_STAGE == MGMT_LOADER |=> chassis_ff == $past(fast_if.phase))
    else $error("chassis indicator not fast blinking in loader");
  AST_BRESP_TIME: assert property (
    wr_fire || (bvalid_ff && !S_AXI_BREADY) |=> bvalid_ff)
    else $error("write response dropped before accepted");

  COV_GREEN_SOLID: cover property (disp_ff == DISP_GREEN_SOLID);
  COV_GREEN_TO_AMBER: cover property (
    disp_ff == DISP_GREEN_BLINK ##1 disp_ff == DISP_AMBER_BLINK);
  COV_FATAL: cover property (disp_ff == DISP_AMBER_SOLID);
  COV_IRQ: cover property (IRQ);
endmodule

// ### testbench/sslenc_led_model.sv
// Model of the bi-colour status indicator: lit cycles per element.
// Assumes LED inputs registered on the system clock.
`timescale 1ns/1ps
module sslenc_led_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic green,
  input wire logic amber,
  output logic [7:0] g_cnt,
  output logic [7:0] a_cnt
);
  // ****
  // Counters
  // ****
  // Each element counted alone, both may be dark
  always @(posedge clk) begin
    if (clr) begin
      g_cnt <= 8'h0;
      a_cnt <= 8'h0;
    end else begin
      g_cnt <= g_cnt + {7'h0, green};
      a_cnt <= a_cnt + {7'h0, amber};
    end
  end
endmodule

// ### testbench/tb_top.sv
// Bench: condition table, AXI4-Lite register access, interrupt.
// Assumes a shortened blink divider and the LED model.
`timescale 1ns/1ps
module tb_top;
  import sslenc_pkg::*;
  logic CLK_SYS, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ, clr;
  logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB, CRIT_THRESH;
  logic [3:0] FAN_OK_COUNT;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic SYS_POWERED, LOW_STANDBY_OFF_STATE, AC_PRESENT, FAN_WARN;
  logic PSU_REDUNDANCY_LOST, FAN_REDUNDANCY_LOST, FAN_FAIL, POWER_GOOD;
  logic PROCESSOR_HOT_FLAG, PSU_PREDICTIVE_FAIL, MEM_DIMM_DISABLED;
  logic MEM_MIRROR_ERR, MGMT_WATCHDOG_RESET, BATTERY_FAIL, DRIVE_FAULT;
  logic PWR_UNIT_CFG_ERR, DRIVE_HOT_SWAP_CONTROLLER_FAULT, THERMAL_TRIP;
  logic REGULATOR_OVERTEMP_FLAG, PWR_UNIT_INSUFFICIENT, MEM_UNCORRECTABLE;
  logic PROCESSOR_CATASTROPHIC_ERROR, LED_GREEN, LED_AMBER, CHASSIS_ID_LED;
  logic [4:0] NONCRIT_THRESH;
  logic [7:0] SPARE_MIGRATE_DIMM, DIMM_FAULT_LED, g_cnt, a_cnt;
  sslenc_sleep_t SLEEP_STATE;
  sslenc_mgmt_t MGMT_BOOT_STAGE;
  int failures = 0;
  int tests_run = 0;
  int e;
  int exp_t [25] = '{1,0,0,0,0,2,2,2,2,2,2,2,2,2,2,3,3,3,4,3,1,4,4,4,4};

  sslenc_top #(.SLOW_HALF_CYC(4), .FAST_HALF_CYC(2)) sslenc_top_inst (
    .CLK_SYS, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .SYS_POWERED, .LOW_STANDBY_OFF_STATE, .SLEEP_STATE,
    .AC_PRESENT, .MGMT_BOOT_STAGE, .PSU_REDUNDANCY_LOST, .FAN_REDUNDANCY_LOST,
    .FAN_WARN, .FAN_FAIL, .FAN_OK_COUNT, .NONCRIT_THRESH, .CRIT_THRESH,
    .PROCESSOR_HOT_FLAG, .PSU_PREDICTIVE_FAIL, .MEM_DIMM_DISABLED,
    .MEM_MIRROR_ERR, .SPARE_MIGRATE_DIMM, .MGMT_WATCHDOG_RESET,
    .BATTERY_FAIL, .PWR_UNIT_CFG_ERR, .DRIVE_HOT_SWAP_CONTROLLER_FAULT,
    .REGULATOR_OVERTEMP_FLAG, .DRIVE_FAULT, .PWR_UNIT_INSUFFICIENT,
    .PROCESSOR_CATASTROPHIC_ERROR, .THERMAL_TRIP, .POWER_GOOD,
    .MEM_UNCORRECTABLE, .LED_GREEN, .LED_AMBER, .CHASSIS_ID_LED,
    .DIMM_FAULT_LED, .IRQ);

  sslenc_led_model sslenc_led_model_inst (.clk(CLK_SYS), .clr(clr),
    .green(LED_GREEN), .amber(LED_AMBER), .g_cnt(g_cnt), .a_cnt(a_cnt));

  // ****
  // Tasks
  // ****
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, s, x);
    end
  endtask

  task finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    @(posedge CLK_SYS);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    {pa, pw} = 2'h3;
    while (pa | pw) begin
      @(negedge CLK_SYS);
      {ta, tw} = {pa & S_AXI_AWREADY, pw & S_AXI_WREADY};
      @(posedge CLK_SYS);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      {pa, pw} = {pa & !ta, pw & !tw};
    end
    do @(negedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    chk(S_AXI_BRESP, RESP_OKAY);
    @(posedge CLK_SYS);
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    logic t;
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(negedge CLK_SYS);
      t = S_AXI_ARREADY;
      @(posedge CLK_SYS);
    end while (t !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    rd = S_AXI_RDATA;
    chk(S_AXI_RRESP, RESP_OKAY);
    @(posedge CLK_SYS);
    S_AXI_RREADY <= 1'b0;
  endtask

  // Healthy running board: no condition present
  task healthy;
    {SYS_POWERED, AC_PRESENT, POWER_GOOD} <= 3'h7;
    {LOW_STANDBY_OFF_STATE, PSU_REDUNDANCY_LOST, FAN_REDUNDANCY_LOST,
     FAN_WARN, FAN_FAIL, PROCESSOR_HOT_FLAG, PSU_PREDICTIVE_FAIL,
     MEM_DIMM_DISABLED, MEM_MIRROR_ERR, MGMT_WATCHDOG_RESET, BATTERY_FAIL,
     PWR_UNIT_CFG_ERR, DRIVE_HOT_SWAP_CONTROLLER_FAULT, DRIVE_FAULT,
     REGULATOR_OVERTEMP_FLAG, PWR_UNIT_INSUFFICIENT, THERMAL_TRIP,
     PROCESSOR_CATASTROPHIC_ERROR, MEM_UNCORRECTABLE} <= '0;
    {NONCRIT_THRESH, CRIT_THRESH, SPARE_MIGRATE_DIMM} <= '0;
    SLEEP_STATE <= SLP_S0;
    MGMT_BOOT_STAGE <= MGMT_READY;
    FAN_OK_COUNT <= 4'h4;
  endtask

  // One condition set per table entry
  task fault(input int k);
    case (k)
      1: SYS_POWERED <= 1'b0;
      2: LOW_STANDBY_OFF_STATE <= 1'b1;
      3: SLEEP_STATE <= SLP_S5;
      4: SLEEP_STATE <= SLP_S4;
      5: PSU_REDUNDANCY_LOST <= 1'b1;
      6: {FAN_WARN, FAN_FAIL} <= 2'h3;
      7: NONCRIT_THRESH <= 5'h10;
      8: PSU_PREDICTIVE_FAIL <= 1'b1;
      9: MEM_DIMM_DISABLED <= 1'b1;
      10: SPARE_MIGRATE_DIMM <= 8'h04;
      11: MGMT_BOOT_STAGE <= MGMT_LOADER;
      12: MGMT_BOOT_STAGE <= MGMT_OS_BOOT;
      13: {BATTERY_FAIL, MGMT_WATCHDOG_RESET, PWR_UNIT_CFG_ERR,
           MEM_MIRROR_ERR} <= 4'hf;
      14: DRIVE_HOT_SWAP_CONTROLLER_FAULT <= 1'b1;
      15: CRIT_THRESH <= 4'h8;
      16: {REGULATOR_OVERTEMP_FLAG, DRIVE_FAULT, PWR_UNIT_INSUFFICIENT,
           PROCESSOR_HOT_FLAG} <= 4'hf;
      17: FAN_OK_COUNT <= 4'h1;
      18: PROCESSOR_CATASTROPHIC_ERROR <= 1'b1;
      19: {CRIT_THRESH, BATTERY_FAIL} <= 5'h3;
      20: FAN_REDUNDANCY_LOST <= 1'b1;
      21: THERMAL_TRIP <= 1'b1;
      22: POWER_GOOD <= 1'b0;
      23: MEM_UNCORRECTABLE <= 1'b1;
      24: MGMT_BOOT_STAGE <= MGMT_IMAGE_BAD;
      default: ;
    endcase
  endtask

  // ****
  // Clock, watchdog, main sequence
  // ****
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    repeat (8000) @(posedge CLK_SYS);
    failures++;
    finish_test;
  end

  initial begin
    {RST_N, clr, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    S_AXI_WDATA = '0;
    S_AXI_WSTRB = 4'hf;
    healthy;
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd_reg(ADDR_CTRL);
    chk(rd, CTRL_RESET);
    rd_reg(ADDR_IRQ_MASK);
    chk(rd, 32'h0);
    wr(ADDR_CTRL, 32'h21);
    wr(ADDR_IRQ_MASK, 32'h4);
    for (int k = 0; k < 25; k++) begin
      @(posedge CLK_SYS);
      healthy;
      @(posedge CLK_SYS);
      fault(k);
      repeat (3) @(posedge CLK_SYS);
      clr <= 1'b1;
      @(posedge CLK_SYS);
      clr <= 1'b0;
      repeat (16) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      e = exp_t[k];
      chk(g_cnt, e == 1 ? 16 : e == 2 ? 8 : 0);
      chk(a_cnt, e == 4 ? 16 : e == 3 ? 8 : 0);
      rd_reg(ADDR_STATE);
      chk(rd & 32'h7, e);
      if (k == 10) chk(DIMM_FAULT_LED, 8'h04);
      if (k == 12) chk(CHASSIS_ID_LED, 1'b1);
      if (k == 17) chk(IRQ, 1'b0);
      if (k == 18) begin
        chk(IRQ, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h4);
        repeat (3) @(negedge CLK_SYS);
        chk(IRQ, 1'b0);
      end
    end
    finish_test;
  end
endmodule
